//--- rtl/fewc_pkg.sv
package fewc_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_ERASE_KEY = 8'h94;
  localparam logic [7:0] ADDR_ARM_CTRL = 8'hB2;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'hB7;
  // Erase keys and erased content
  localparam logic [7:0] KEY_MASS = 8'hAA;
  localparam logic [7:0] KEY_PAGE = 8'h55;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Field positions
  localparam int ARM_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int PAGE_LSB = 1;
  localparam int PAGE_W = 7;
  // Flash geometry
  localparam int CE_BASE_SHIFT = 10;
  localparam int CE_PROG_WORDS = 1024;
  localparam int PAGE_SHIFT = 9;
  localparam int FADDR_W = 16;
  // Values after reset
  localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
  localparam logic ARM_RESET = 1'b0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  // Timing at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 1000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_TIME_US = 20000;
  localparam int ERASE_CYCLES = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10
  } fewc_state_t;
endpackage

//--- rtl/fewc_key_seq.sv
`timescale 1ns/1ps
module fewc_key_seq
  import fewc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_arm_wr,
  input wire logic i_page_wr,
  input wire logic i_key_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_debug_port_en,
  input wire logic i_idle,
  output logic o_arm,
  output logic o_page_armed,
  output logic o_mass_go,
  output logic o_page_go
);
  logic arm_reg, arm_next;
  logic page_armed_reg, page_armed_next;
  logic mass_go_reg, mass_go_next;
  logic page_go_reg, page_go_next;

  // Key decode; any key write consumes the pending step so a stale arm cannot fire later
  always_comb begin
    arm_next = arm_reg;
    page_armed_next = page_armed_reg;
    mass_go_next = 1'b0;
    page_go_next = 1'b0;
    if (i_arm_wr) begin
      arm_next = i_wdata[ARM_BIT];
    end
    if (i_page_wr) begin
      page_armed_next = 1'b1;
    end
    if (i_key_wr) begin
      arm_next = 1'b0;
      page_armed_next = 1'b0;
      if (i_wdata == KEY_MASS && arm_reg && i_debug_port_en && i_idle) begin
        mass_go_next = 1'b1;
      end
      if (i_wdata == KEY_PAGE && page_armed_reg && i_idle) begin
        page_go_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      arm_reg <= ARM_RESET;
      page_armed_reg <= 1'b0;
      mass_go_reg <= 1'b0;
      page_go_reg <= 1'b0;
    end else if (i_clk_en) begin
      arm_reg <= arm_next;
      page_armed_reg <= page_armed_next;
      mass_go_reg <= mass_go_next;
      page_go_reg <= page_go_next;
    end
  end

  assign o_arm = arm_reg;
  assign o_page_armed = page_armed_reg;
  assign o_mass_go = mass_go_reg;
  assign o_page_go = page_go_reg;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_mass_key_go: assert property (i_clk_en && i_key_wr && i_wdata == KEY_MASS && arm_reg && i_debug_port_en && i_idle
    |=> o_mass_go) else $error("mass erase key ignored");
  a_mass_needs_dbg: assert property (i_clk_en && !i_debug_port_en |=> !o_mass_go)
    else $error("mass erase without debug port");
  a_page_key_go: assert property (i_clk_en && i_key_wr && i_wdata == KEY_PAGE && page_armed_reg && i_idle
    |=> o_page_go) else $error("page erase key ignored");
  a_bad_key_none: assert property (i_clk_en && i_key_wr && i_wdata != KEY_MASS && i_wdata != KEY_PAGE
    |=> !o_mass_go && !o_page_go) else $error("erase from bad key");
  a_unarmed_none: assert property (i_clk_en && i_key_wr && !page_armed_reg |=> !o_page_go)
    else $error("page erase without select");
endmodule

//--- rtl/fewc_top.sv
`timescale 1ns/1ps
module fewc_top
  import fewc_pkg::*;
#(
  parameter int ERASE_CYCLE_COUNT = ERASE_CYCLES
)(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_debug_port_en,
  input wire logic [4:0] i_engine_program_base,
  input wire logic [9:0] i_ce_fetch_word,
  output logic [FADDR_W-1:0] o_ce_fetch_addr,
  input wire logic i_ce_busy,
  input wire logic i_ce_pass_due,
  output logic o_ce_pass_go,
  output logic o_ce_pass_skip,
  input wire logic i_flash_access_speed_select,
  output logic o_flash_speed_sel,
  input wire logic i_program_write_route,
  input wire logic i_store_wr,
  input wire logic [FADDR_W-1:0] i_store_addr,
  input wire logic [7:0] i_store_data,
  output logic o_xram_wr,
  output logic [FADDR_W-1:0] o_xram_addr,
  output logic [7:0] o_xram_wdata,
  output logic o_flash_wr,
  output logic o_flash_page_erase,
  output logic o_flash_mass_erase,
  output logic [FADDR_W-1:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic o_flash_busy,
  output logic o_write_rejected_collision,
  output logic o_pass_skipped_collision
);
  localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYCLE_COUNT - 1);

  // SFR write decode, used for every register
  function automatic logic sfr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = wr && (addr == target);
  endfunction

  fewc_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [PAGE_W-1:0] page_reg, page_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [FADDR_W-1:0] fetch_reg, fetch_next;
  logic speed_reg, speed_next;
  logic pass_go_reg, pass_go_next, pass_skip_reg, pass_skip_next;
  logic xwr_reg, xwr_next;
  logic [FADDR_W-1:0] xaddr_reg, xaddr_next, faddr_reg, faddr_next;
  logic [7:0] xdata_reg, xdata_next, fdata_reg, fdata_next;
  logic fwr_reg, fwr_next, fpage_reg, fpage_next, fmass_reg, fmass_next;
  logic rej_reg, rej_next, skip_col_reg, skip_col_next;
  logic arm, page_armed, mass_go, page_go, idle;

  assign idle = (state_reg == ST_IDLE);

  fewc_key_seq u_key_seq (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_arm_wr(sfr_hit(i_sfr_wr, i_sfr_addr, ADDR_ARM_CTRL)),
    .i_page_wr(sfr_hit(i_sfr_wr, i_sfr_addr, ADDR_PAGE_SEL)),
    .i_key_wr(sfr_hit(i_sfr_wr, i_sfr_addr, ADDR_ERASE_KEY)),
    .i_wdata(i_sfr_wdata),
    .i_debug_port_en(i_debug_port_en),
    .i_idle(idle),
    .o_arm(arm),
    .o_page_armed(page_armed),
    .o_mass_go(mass_go),
    .o_page_go(page_go)
  );

  // Register file and pass-through controls
  always_comb begin
    page_next = page_reg;
    rdata_next = rdata_reg;
    if (sfr_hit(i_sfr_wr, i_sfr_addr, ADDR_PAGE_SEL)) begin
      page_next = i_sfr_wdata[PAGE_LSB +: PAGE_W];
    end
    // Key register is write only; unmapped reads return zero
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_ARM_CTRL: rdata_next = {6'h00, arm, !idle};
        ADDR_PAGE_SEL: rdata_next = {page_reg, 1'b0};
        default: rdata_next = 8'h00;
      endcase
    end
    // Engine code starts on a 1KB boundary
    fetch_next = FADDR_W'({i_engine_program_base, 10'h000}) + FADDR_W'({i_ce_fetch_word, 1'b0});
    // Flash access speed follows its bit
    speed_next = i_flash_access_speed_select;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      page_reg <= PAGE_RESET;
      rdata_reg <= RDATA_RESET;
      fetch_reg <= '0;
      speed_reg <= 1'b0;
    end else if (i_clk_en) begin
      page_reg <= page_next;
      rdata_reg <= rdata_next;
      fetch_reg <= fetch_next;
      speed_reg <= speed_next;
    end
  end

  // Flash operation sequencer; a pass due in ST_WRITE or ST_ERASE is skipped, and erase starts even while i_ce_busy
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pass_go_next = 1'b0;
    pass_skip_next = 1'b0;
    xwr_next = 1'b0;
    xaddr_next = xaddr_reg;
    xdata_next = xdata_reg;
    fwr_next = 1'b0;
    fpage_next = 1'b0;
    fmass_next = 1'b0;
    faddr_next = faddr_reg;
    fdata_next = fdata_reg;
    rej_next = 1'b0;
    skip_col_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (mass_go || page_go) begin
          state_next = ST_ERASE;
          cnt_next = ERASE_LOAD;
          fmass_next = mass_go;
          fpage_next = page_go && !mass_go;
          // Page number scaled to 512-byte page
          faddr_next = FADDR_W'({page_reg, 9'h000});
          fdata_next = ERASED_BYTE;
        end else if (i_store_wr && i_program_write_route) begin
          // Write during engine busy is dropped
          if (i_ce_busy) begin
            rej_next = 1'b1;
          end else begin
            state_next = ST_WRITE;
            cnt_next = WRITE_LOAD;
            fwr_next = 1'b1;
            faddr_next = i_store_addr;
            fdata_next = i_store_data;
          end
        end
      end
      ST_WRITE, ST_ERASE: begin
        if (cnt_reg == CNT_RESET) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Flash stores outside idle are lost; firmware must pace them
    if (i_store_wr && !i_program_write_route) begin
      // Route bit clear sends the store to XRAM
      xwr_next = 1'b1;
      xaddr_next = i_store_addr;
      xdata_next = i_store_data;
    end
    if (i_ce_pass_due) begin
      if (state_reg == ST_WRITE) begin
        pass_skip_next = 1'b1;
        skip_col_next = 1'b1;
      end else if (state_reg == ST_ERASE) begin
        pass_skip_next = 1'b1;
      end else begin
        pass_go_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_RESET;
      pass_go_reg <= 1'b0;
      pass_skip_reg <= 1'b0;
      xwr_reg <= 1'b0;
      xaddr_reg <= '0;
      xdata_reg <= 8'h00;
      fwr_reg <= 1'b0;
      fpage_reg <= 1'b0;
      fmass_reg <= 1'b0;
      faddr_reg <= '0;
      fdata_reg <= ERASED_BYTE;
      rej_reg <= 1'b0;
      skip_col_reg <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pass_go_reg <= pass_go_next;
      pass_skip_reg <= pass_skip_next;
      xwr_reg <= xwr_next;
      xaddr_reg <= xaddr_next;
      xdata_reg <= xdata_next;
      fwr_reg <= fwr_next;
      fpage_reg <= fpage_next;
      fmass_reg <= fmass_next;
      faddr_reg <= faddr_next;
      fdata_reg <= fdata_next;
      rej_reg <= rej_next;
      skip_col_reg <= skip_col_next;
    end
  end

  // Outputs straight from flops, except busy, which is decoded from state_reg
  assign o_sfr_rdata = rdata_reg;
  assign o_ce_fetch_addr = fetch_reg;
  assign o_flash_speed_sel = speed_reg;
  assign o_ce_pass_go = pass_go_reg;
  assign o_ce_pass_skip = pass_skip_reg;
  assign o_xram_wr = xwr_reg;
  assign o_xram_addr = xaddr_reg;
  assign o_xram_wdata = xdata_reg;
  assign o_flash_wr = fwr_reg;
  assign o_flash_page_erase = fpage_reg;
  assign o_flash_mass_erase = fmass_reg;
  assign o_flash_addr = faddr_reg;
  assign o_flash_wdata = fdata_reg;
  assign o_flash_busy = !idle;
  assign o_write_rejected_collision = rej_reg;
  assign o_pass_skipped_collision = skip_col_reg;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_reject_busy: assert property (i_clk_en && idle && !mass_go && !page_go && i_store_wr && i_program_write_route
    && i_ce_busy |=> o_write_rejected_collision && !o_flash_wr && idle) else $error("busy write not rejected");
  a_pass_skip: assert property (i_clk_en && state_reg == ST_WRITE && i_ce_pass_due
    |=> o_pass_skipped_collision && o_ce_pass_skip && !o_ce_pass_go) else $error("pass not skipped");
  a_write_finish: assert property (i_clk_en && state_reg == ST_WRITE && cnt_reg != CNT_RESET
    |=> state_reg == ST_WRITE) else $error("write cut short");
  a_fetch_base: assert property (i_clk_en |=> o_ce_fetch_addr[9:0] == {$past(i_ce_fetch_word[8:0]), 1'b0}
    && o_ce_fetch_addr[14:10] == $past(i_engine_program_base) + 5'($past(i_ce_fetch_word[9])))
    else $error("fetch address wrong");
  a_page_align: assert property (o_flash_page_erase |-> o_flash_addr[8:0] == 9'h000 && o_flash_busy)
    else $error("erase not page aligned");
  a_speed_sel: assert property (i_clk_en |=> o_flash_speed_sel == $past(i_flash_access_speed_select))
    else $error("speed bit not applied");
  a_route_xram: assert property (i_clk_en && i_store_wr && !i_program_write_route |=> o_xram_wr && !o_flash_wr)
    else $error("store not routed to xram");
  a_erase_fill: assert property (o_flash_page_erase || o_flash_mass_erase |-> o_flash_wdata == ERASED_BYTE)
    else $error("erase fill not all ones");
  a_mass_start: assert property (i_clk_en && mass_go && idle |=> o_flash_mass_erase && state_reg == ST_ERASE)
    else $error("mass erase not started");

  c_flash_write: cover property (o_flash_wr);
  c_reject: cover property (o_write_rejected_collision);
  c_skip: cover property (o_pass_skipped_collision);
  c_page_erase: cover property (o_flash_page_erase);
endmodule

//--- testbench/fewc_flash_model.sv
`timescale 1ns/1ps
module fewc_flash_model (
  input wire logic i_clock,
  input wire logic i_wr,
  input wire logic i_page_erase,
  input wire logic i_mass_erase,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata
);
  logic [7:0] mem [0:65535];
  // Array starts out blank
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hFF;
    end
  end
  // Erase is page wide or whole array, never smaller
  // Writes can only clear bits, so a rewrite needs an erase
  always @(posedge i_clock) begin
    if (i_wr) begin
      mem[i_addr] <= mem[i_addr] & i_wdata;
    end
    if (i_page_erase) begin
      for (int i = 0; i < 512; i++) begin
        mem[{i_addr[15:9], 9'h000} + i] <= 8'hFF;
      end
    end
    if (i_mass_erase) begin
      for (int i = 0; i < 65536; i++) begin
        mem[i] <= 8'hFF;
      end
    end
  end
endmodule

//--- testbench/test_flash_erase_write_control.sv
`timescale 1ns/1ps
module test_flash_erase_write_control;
  import fewc_pkg::*;
  logic i_clock, i_rstn, i_clk_en, i_sfr_wr, i_sfr_rd, i_debug_port_en, i_ce_busy, i_ce_pass_due;
  logic i_flash_access_speed_select, i_program_write_route, i_store_wr;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_store_data, o_xram_wdata, o_flash_wdata;
  logic [4:0] i_engine_program_base;
  logic [9:0] i_ce_fetch_word;
  logic [15:0] o_ce_fetch_addr, i_store_addr, o_xram_addr, o_flash_addr;
  logic o_ce_pass_go, o_ce_pass_skip, o_flash_speed_sel, o_xram_wr, o_flash_wr, o_flash_page_erase;
  logic o_flash_mass_erase, o_flash_busy, o_write_rejected_collision, o_pass_skipped_collision;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int pe_n = 0;
  int me_n = 0;
  fewc_top #(.ERASE_CYCLE_COUNT(20)) dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_debug_port_en(i_debug_port_en),
    .i_engine_program_base(i_engine_program_base), .i_ce_fetch_word(i_ce_fetch_word),
    .o_ce_fetch_addr(o_ce_fetch_addr), .i_ce_busy(i_ce_busy), .i_ce_pass_due(i_ce_pass_due),
    .o_ce_pass_go(o_ce_pass_go), .o_ce_pass_skip(o_ce_pass_skip),
    .i_flash_access_speed_select(i_flash_access_speed_select), .o_flash_speed_sel(o_flash_speed_sel),
    .i_program_write_route(i_program_write_route), .i_store_wr(i_store_wr), .i_store_addr(i_store_addr),
    .i_store_data(i_store_data), .o_xram_wr(o_xram_wr), .o_xram_addr(o_xram_addr),
    .o_xram_wdata(o_xram_wdata), .o_flash_wr(o_flash_wr), .o_flash_page_erase(o_flash_page_erase),
    .o_flash_mass_erase(o_flash_mass_erase), .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata),
    .o_flash_busy(o_flash_busy), .o_write_rejected_collision(o_write_rejected_collision),
    .o_pass_skipped_collision(o_pass_skipped_collision));
  fewc_flash_model fm (.i_clock(i_clock), .i_wr(o_flash_wr), .i_page_erase(o_flash_page_erase),
    .i_mass_erase(o_flash_mass_erase), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata));
  // Free running clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Erase start counters and hang guard
  always @(posedge i_clock) begin
    pe_n += (o_flash_page_erase === 1'b1);
    me_n += (o_flash_mass_erase === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr_wr <= 1'b1;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    @(posedge i_clock);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_sfr_rd <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_clock);
    i_sfr_rd <= 1'b0;
    @(negedge i_clock);
    chk(o_sfr_rdata, exp, "register read");
  endtask
  // Data store; outputs are looked at in the answer cycle
  task automatic store(input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_program_write_route <= r;
    i_store_wr <= 1'b1;
    i_store_addr <= a;
    i_store_data <= d;
    @(posedge i_clock);
    i_store_wr <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic pass_due();
    @(posedge i_clock);
    i_ce_pass_due <= 1'b1;
    @(posedge i_clock);
    i_ce_pass_due <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_flash_busy !== 1'b0 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    chk(o_flash_busy, 1'b0, "busy never fell");
  endtask
  task automatic t_fetch_speed();
    @(posedge i_clock);
    // Base field set before the engine is started
    i_engine_program_base <= 5'h1F;
    // Last word of a 1024-word program
    i_ce_fetch_word <= 10'h3FF;
    i_flash_access_speed_select <= 1'b1;
    repeat (3) @(negedge i_clock);
    chk(o_ce_fetch_addr, 16'h83FE, "fetch address top");
    chk(o_flash_speed_sel, 1'b1, "speed select");
    @(posedge i_clock);
    i_engine_program_base <= 5'h01;
    i_ce_fetch_word <= 10'h000;
    i_flash_access_speed_select <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk(o_ce_fetch_addr, 16'h0400, "fetch address base");
    chk(o_flash_speed_sel, 1'b0, "speed select low");
    // Clock enable low must hold every register
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    i_flash_access_speed_select <= 1'b1;
    repeat (3) @(negedge i_clock);
    chk(o_flash_speed_sel, 1'b0, "frozen by clock enable");
    @(posedge i_clock);
    i_clk_en <= 1'b1;
  endtask
  task automatic t_route();
    store(1'b0, 16'h0123, 8'hA5);
    chk({o_xram_wr, o_flash_wr}, 2'b10, "xram route");
    chk(o_xram_addr ^ o_xram_wdata, 16'h0186, "xram addr data");
    store(1'b1, 16'h0403, 8'h3C);
    chk({o_xram_wr, o_flash_wr, o_flash_busy}, 3'b011, "flash route");
    wait_idle();
    chk(fm.mem[16'h0403], 8'h3C, "flash byte");
    store(1'b1, 16'h0600, 8'h5A);
    wait_idle();
  endtask
  task automatic t_collide();
    @(posedge i_clock);
    i_ce_busy <= 1'b1;
    store(1'b1, 16'h0010, 8'h00);
    chk({o_write_rejected_collision, o_flash_wr}, 2'b10, "write during pass");
    @(posedge i_clock);
    i_ce_busy <= 1'b0;
    repeat (3) @(negedge i_clock);
    chk(fm.mem[16'h0010], 8'hFF, "discarded write");
    // Single flash write starts once the engine pass has ended
    store(1'b1, 16'h0011, 8'h11);
    pass_due();
    chk({o_ce_pass_skip, o_pass_skipped_collision, o_ce_pass_go}, 3'b110, "pass in write");
    wait_idle();
    chk(fm.mem[16'h0011], 8'h11, "write completed");
    pass_due();
    chk({o_ce_pass_skip, o_pass_skipped_collision, o_ce_pass_go}, 3'b001, "pass when idle");
  endtask
  task automatic t_bad_keys();
    int n;
    n = pe_n + me_n;
    // Debug port on, so only the key sequence holds the erase back
    @(posedge i_clock);
    i_debug_port_en <= 1'b1;
    sfr_wr(ADDR_ERASE_KEY, KEY_MASS);
    sfr_wr(ADDR_ERASE_KEY, KEY_PAGE);
    sfr_wr(ADDR_ARM_CTRL, 8'h02);
    sfr_wr(ADDR_ERASE_KEY, 8'h12);
    sfr_wr(ADDR_ERASE_KEY, KEY_MASS);
    repeat (4) @(negedge i_clock);
    chk(pe_n + me_n - n, 0, "stray erase");
    sfr_rd(ADDR_ERASE_KEY, 8'h00);
    sfr_rd(8'h00, 8'h00);
    @(posedge i_clock);
    i_debug_port_en <= 1'b0;
  endtask
  task automatic t_page();
    int n;
    n = pe_n;
    sfr_wr(ADDR_PAGE_SEL, 8'h05);
    sfr_rd(ADDR_PAGE_SEL, 8'h04);
    sfr_wr(ADDR_ERASE_KEY, KEY_PAGE);
    repeat (4) @(negedge i_clock);
    chk(pe_n - n, 1, "page erase start");
    chk(o_flash_addr, 16'h0400, "page address");
    chk(o_flash_wdata, ERASED_BYTE, "erase fill");
    pass_due();
    chk({o_ce_pass_skip, o_pass_skipped_collision, o_ce_pass_go}, 3'b100, "pass in erase");
    wait_idle();
    chk(fm.mem[16'h0403], ERASED_BYTE, "page erased");
    chk(fm.mem[16'h0600], 8'h5A, "next page kept");
  endtask
  task automatic t_mass();
    int n;
    n = me_n;
    sfr_wr(ADDR_ARM_CTRL, 8'h02);
    sfr_rd(ADDR_ARM_CTRL, 8'h02);
    sfr_wr(ADDR_ERASE_KEY, KEY_MASS);
    repeat (4) @(negedge i_clock);
    chk(me_n - n, 0, "mass erase without debug port");
    @(posedge i_clock);
    i_debug_port_en <= 1'b1;
    sfr_wr(ADDR_ARM_CTRL, 8'h02);
    sfr_wr(ADDR_ERASE_KEY, KEY_MASS);
    repeat (4) @(negedge i_clock);
    chk(me_n - n, 1, "mass erase start");
    sfr_rd(ADDR_ARM_CTRL, 8'h01);
    wait_idle();
    chk(fm.mem[16'h0600], ERASED_BYTE, "array erased");
  endtask
  // Main sequence
  initial begin
    {i_sfr_wr, i_sfr_rd, i_debug_port_en, i_ce_busy, i_ce_pass_due} = 5'h00;
    {i_flash_access_speed_select, i_program_write_route, i_store_wr} = 3'h0;
    {i_sfr_addr, i_sfr_wdata, i_store_data, i_engine_program_base, i_ce_fetch_word} = 39'h0;
    i_store_addr = 16'h0000;
    i_clk_en = 1'b1;
    i_rstn = 1'b0;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(negedge i_clock);
    chk({o_flash_busy, o_flash_wdata, o_sfr_rdata}, 17'h0FF00, "reset values");
    sfr_rd(ADDR_ARM_CTRL, 8'h00);
    t_fetch_speed();
    t_route();
    t_collide();
    t_bad_keys();
    t_page();
    t_mass();
    print_verdict();
  end
endmodule
